// [design/scp_chan.sv]
module scp_chan (
    // core side
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       tx_en_i,
    input  wire logic       rx_en_i,
    input  wire logic       loop_i,
    input  wire logic       tx_load_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       rx_take_i,
    output logic            tx_room_o,
    output logic            tx_busy_o,
    output logic            rx_avail_o,
    output logic            rx_ovr_o,
    output logic      [7:0] rx_data_o,
    // link side
    input  wire logic       link_clk_i,
    input  wire logic       serial_in_i,
    output logic            serial_out_o
);
    // transmit word held in core domain, handshake by toggle
    logic [7:0] txw_r;
    logic       tx_req_r;
    logic       tx_full_r;
    logic       tx_ack_s;
    logic       tx_ack_seen_r;
    logic       l_tx_req_s;
    logic       l_tx_ack_r;
    logic [8:0] l_sh_r;
    logic [3:0] l_cnt_r;
    logic       l_txen_s;
    logic       l_loop_s;
    logic       l_rxen_s;
    logic       l_out_r;
    logic [7:0] l_rsh_r;
    logic [2:0] l_rcnt_r;
    logic       l_rbusy_r;
    logic [7:0] l_rword_r;
    logic       l_rtog_r;
    logic       rtog_s;
    logic       rtog_seen_r;
    logic       rx_ovr_r;

    scp_sync2 #(.W(4)) u_to_link (
        .clk_i (link_clk_i),
        .rst_i (rst_i),
        .d_i   ({tx_req_r, tx_en_i, loop_i, rx_en_i}),
        .q_o   ({l_tx_req_s, l_txen_s, l_loop_s, l_rxen_s})
    );
    scp_sync2 #(.W(2)) u_to_core (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .d_i   ({l_tx_ack_r, l_rtog_r}),
        .q_o   ({tx_ack_s, rtog_s})
    );

    // core: one-word transmit holding register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            txw_r         <= 8'h00;
            tx_req_r      <= 1'b0;
            tx_full_r     <= 1'b0;
            tx_ack_seen_r <= 1'b0;
        end else begin
            tx_ack_seen_r <= tx_ack_s;
            if (tx_ack_s != tx_ack_seen_r) begin
                tx_full_r <= 1'b0;
            end
            if (tx_load_i && !tx_full_r) begin
                txw_r     <= tx_data_i;
                tx_full_r <= 1'b1;
                tx_req_r  <= ~tx_req_r;
            end
        end
    end
    assign tx_room_o = ~tx_full_r;
    assign tx_busy_o = tx_full_r;

    // link: shifter, lsb first, shifts on falling edge
    always_ff @(negedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l_sh_r     <= 9'h1FF;
            l_cnt_r    <= 4'h0;
            l_tx_ack_r <= 1'b0;
            l_out_r    <= 1'b1;
        end else begin
            if (l_cnt_r != 4'h0) begin
                l_out_r <= l_sh_r[0];
                l_sh_r  <= {1'b1, l_sh_r[8:1]};
                l_cnt_r <= l_cnt_r - 4'h1;
            end else if (l_tx_req_s != l_tx_ack_r && l_txen_s) begin
                // txw_r stable while request pending
                l_out_r    <= 1'b0;
                l_sh_r     <= {1'b1, txw_r};
                l_cnt_r    <= 4'd9;
                l_tx_ack_r <= l_tx_req_s;
            end else begin
                l_out_r <= 1'b1;
            end
        end
    end
    // marking while disabled or looped back
    assign serial_out_o = (l_txen_s && !l_loop_s) ? l_out_r : 1'b1;

    // link: receiver samples on rising edge, lsb first
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l_rsh_r   <= 8'h00;
            l_rcnt_r  <= 3'h0;
            l_rbusy_r <= 1'b0;
            l_rword_r <= 8'h00;
            l_rtog_r  <= 1'b0;
        end else if (!l_rxen_s) begin
            l_rbusy_r <= 1'b0;
        end else if (!l_rbusy_r) begin
            if (!(l_loop_s ? l_out_r : serial_in_i)) begin
                l_rbusy_r <= 1'b1;
                l_rcnt_r  <= 3'h0;
            end
        end else begin
            l_rsh_r  <= {(l_loop_s ? l_out_r : serial_in_i), l_rsh_r[7:1]};
            l_rcnt_r <= l_rcnt_r + 3'h1;
            if (l_rcnt_r == 3'h7) begin
                l_rbusy_r <= 1'b0;
                l_rword_r <= {(l_loop_s ? l_out_r : serial_in_i), l_rsh_r[7:1]};
                l_rtog_r  <= ~l_rtog_r;
            end
        end
    end

    // core: received word holding, overrun flag
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rtog_seen_r <= 1'b0;
            rx_avail_o  <= 1'b0;
            rx_data_o   <= 8'h00;
            rx_ovr_r    <= 1'b0;
        end else begin
            rtog_seen_r <= rtog_s;
            if (rtog_s != rtog_seen_r) begin
                rx_data_o  <= l_rword_r;
                rx_avail_o <= 1'b1;
                if (rx_avail_o && !rx_take_i) begin
                    rx_ovr_r <= 1'b1;
                end
            end else if (rx_take_i) begin
                rx_avail_o <= 1'b0;
            end
        end
    end
    assign rx_ovr_o = rx_ovr_r;
endmodule // scp_chan

// [design/scp_pkg.sv]
package scp_pkg;
    // widths of the host side
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;

    // register indices on the select lines
    localparam logic [5:0] REG_CFG_A  = 6'h00;
    localparam logic [5:0] REG_TXQ_A  = 6'h01;
    localparam logic [5:0] REG_RXQ_A  = 6'h02;
    localparam logic [5:0] REG_STAT_A = 6'h03;
    localparam logic [5:0] REG_CFG_B  = 6'h10;
    localparam logic [5:0] REG_TXQ_B  = 6'h11;
    localparam logic [5:0] REG_RXQ_B  = 6'h12;
    localparam logic [5:0] REG_STAT_B = 6'h13;
    localparam logic [5:0] REG_IEN    = 6'h20;
    localparam logic [5:0] REG_GSTAT  = 6'h21;
    localparam logic [5:0] REG_IVEC   = 6'h22;
    localparam logic [5:0] REG_ICTL   = 6'h23;

    // reset values
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] IEN_RST  = 8'h00;
    localparam logic [7:0] IVEC_RST = 8'h0F;
    localparam logic [7:0] ICTL_RST = 8'h00;

    // channel config field positions
    localparam int unsigned CFG_TXEN = 0;
    localparam int unsigned CFG_RXEN = 1;
    localparam int unsigned CFG_LOOP = 2;
    localparam int unsigned CFG_WM_LO = 3;
    localparam int unsigned CFG_C1_LO = 5;
    localparam int unsigned CFG_C2_LO = 6;

    // wait modes
    typedef enum logic [1:0] {
        SCP_WAIT_OFF = 2'b00,
        SCP_WAIT_RX  = 2'b01,
        SCP_WAIT_TX  = 2'b10,
        SCP_WAIT_ANY = 2'b11
    } scp_wait_t;

    // answer to interrupt acknowledge
    typedef enum logic [1:0] {
        SCP_ACK_FLOAT = 2'b00,
        SCP_ACK_VEC   = 2'b01,
        SCP_ACK_CALL  = 2'b10,
        SCP_ACK_ZERO  = 2'b11
    } scp_ackm_t;

    localparam logic [7:0] CALL_OPCODE = 8'hCD;
    localparam int unsigned VEC_MOD_BIT = 2;

    // rate generator: 16x divider of the core clock
    localparam int unsigned BRG_DIV = 16;

    // per-channel status bundle
    typedef struct packed {
        logic rx_avail;
        logic tx_room;
        logic rx_overrun;
        logic tx_busy;
    } scp_chst_t;
endpackage

// [design/scp_sync2.sv]
module scp_sync2 #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // level in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // two-stage synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule // scp_sync2

// [design/scp_top.sv]
// Operation
// - register select lines choose the register a cycle reaches
// - all transfers use one eight-bit bus, bit 0 least significant
// - read strobe with chip select drives addressed register onto bus
// - write with chip select loads register on write strobe rising edge
// - bus floats without chip select, except interrupt acknowledge
// - wait line driven only in wait modes during read or write
// - wait asserts when reading empty receive or writing full transmit
// - interrupt request asserts on any enabled condition
// - acknowledge answers float, vector, call or zero as programmed
// - acknowledge with nothing pending is ignored, bus floats
// - master reset clears transmitters, receivers, registers asynchronously, except vector register which loads 0x0F
// - receiver takes lsb first, samples on rising link clock
// - transmitter sends lsb first, marks when disabled or looped
// - external transmit clock shifts data on falling edge
// - first clock pin output always gives the transmit clock
// - second clock pin gives half system clock, else rate generator on channel a, receive clock on channel b
// - core clock feeds channel a rate generator and internal timing
module scp_top (
    // core clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // host bus
    input  wire logic [5:0] register_select_lines_i,
    input  wire logic [7:0] host_data_bus_i,
    output logic      [7:0] host_data_bus_o,
    output logic            host_data_bus_oe_o,
    input  wire logic       read_strobe_n_i,
    input  wire logic       write_strobe_n_i,
    input  wire logic       chip_select_n_i,
    input  wire logic       interrupt_ack_n_i,
    output logic            wait_ready_n_o,
    output logic            wait_ready_n_oe_o,
    output logic            interrupt_request_n_o,
    output logic            interrupt_request_n_oe_o,
    // channel a link
    input  wire logic       link_clk_a_i,
    input  wire logic       serial_in_chan_a_i,
    output logic            serial_out_chan_a_o,
    output logic            first_clock_pin_a_o,
    output logic            first_clock_pin_a_oe_o,
    output logic            second_clock_pin_a_o,
    output logic            second_clock_pin_a_oe_o,
    // channel b link
    input  wire logic       link_clk_b_i,
    input  wire logic       serial_in_chan_b_i,
    output logic            serial_out_chan_b_o,
    output logic            first_clock_pin_b_o,
    output logic            first_clock_pin_b_oe_o,
    output logic            second_clock_pin_b_o,
    output logic            second_clock_pin_b_oe_o
);
    // synchronised pins
    logic [5:0] sel_s;
    logic [7:0] din_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic       cs_n_s;
    logic       ack_n_s;
    logic       wr_n_d_r;
    logic       rd_n_d_r;
    logic [7:0] cfg_r [2];
    logic [7:0] ien_r;
    logic [7:0] ivec_r;
    logic [7:0] ictl_r;
    logic [7:0] rd_mux;
    logic [7:0] ack_val;
    logic       tx_load [2];
    logic       rx_take [2];
    scp_pkg::scp_chst_t st [2];
    logic [7:0] rxd [2];
    logic [7:0] gstat;
    logic       irq_any;
    logic       rd_cyc;
    logic       wr_cyc;
    logic       wr_rise;
    logic       rd_fall;
    logic       rd_block;
    logic       wr_block;
    logic       wait_r;
    logic       sysclk_r;
    logic [3:0] brg_cnt_r;
    logic       brg16_r;
    logic       ch_txq;
    logic       ch_rxq;
    logic       ch_sel;
    logic       txclk [2];
    logic       rxclk [2];
    logic [1:0] wm;

    scp_sync2 #(.W(18)) u_pin_sync (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .d_i   ({register_select_lines_i, host_data_bus_i, read_strobe_n_i,
                 write_strobe_n_i, chip_select_n_i, interrupt_ack_n_i}),
        .q_o   ({sel_s, din_s, rd_n_s, wr_n_s, cs_n_s, ack_n_s})
    );

    assign ch_sel = sel_s[4];
    assign ch_txq = (sel_s == scp_pkg::REG_TXQ_A) || (sel_s == scp_pkg::REG_TXQ_B);
    assign ch_rxq = (sel_s == scp_pkg::REG_RXQ_A) || (sel_s == scp_pkg::REG_RXQ_B);
    assign rd_cyc = !cs_n_s && !rd_n_s;
    assign wr_cyc = !cs_n_s && !wr_n_s;
    assign wr_rise = !cs_n_s && wr_n_s && !wr_n_d_r;
    assign rd_fall = rd_cyc && rd_n_d_r;

    // strobe history for edge detection
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_n_d_r <= 1'b1;
            rd_n_d_r <= 1'b1;
        end else begin
            wr_n_d_r <= wr_n_s;
            rd_n_d_r <= rd_n_s;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r[0] <= scp_pkg::CFG_RST;
            cfg_r[1] <= scp_pkg::CFG_RST;
            ien_r    <= scp_pkg::IEN_RST;
            ivec_r   <= scp_pkg::IVEC_RST;
            ictl_r   <= scp_pkg::ICTL_RST;
        end else if (wr_rise) begin
            case (sel_s)
                scp_pkg::REG_CFG_A: cfg_r[0] <= din_s;
                scp_pkg::REG_CFG_B: cfg_r[1] <= din_s;
                scp_pkg::REG_IEN:   ien_r    <= din_s;
                scp_pkg::REG_IVEC:  ivec_r   <= din_s;
                scp_pkg::REG_ICTL:  ictl_r   <= din_s;
                default: ;
            endcase
        end
    end

    // queue strobes: write at rising edge, read at end of read
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            tx_load[i] = wr_rise && ch_txq && (ch_sel == i[0]);
            rx_take[i] = !cs_n_s && rd_n_s && !rd_n_d_r && ch_rxq && (ch_sel == i[0]);
        end
    end

    scp_chan u_chan_a (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .tx_en_i      (cfg_r[0][scp_pkg::CFG_TXEN]),
        .rx_en_i      (cfg_r[0][scp_pkg::CFG_RXEN]),
        .loop_i       (cfg_r[0][scp_pkg::CFG_LOOP]),
        .tx_load_i    (tx_load[0]),
        .tx_data_i    (din_s),
        .rx_take_i    (rx_take[0]),
        .tx_room_o    (st[0].tx_room),
        .tx_busy_o    (st[0].tx_busy),
        .rx_avail_o   (st[0].rx_avail),
        .rx_ovr_o     (st[0].rx_overrun),
        .rx_data_o    (rxd[0]),
        .link_clk_i   (link_clk_a_i),
        .serial_in_i  (serial_in_chan_a_i),
        .serial_out_o (serial_out_chan_a_o)
    );
    scp_chan u_chan_b (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .tx_en_i      (cfg_r[1][scp_pkg::CFG_TXEN]),
        .rx_en_i      (cfg_r[1][scp_pkg::CFG_RXEN]),
        .loop_i       (cfg_r[1][scp_pkg::CFG_LOOP]),
        .tx_load_i    (tx_load[1]),
        .tx_data_i    (din_s),
        .rx_take_i    (rx_take[1]),
        .tx_room_o    (st[1].tx_room),
        .tx_busy_o    (st[1].tx_busy),
        .rx_avail_o   (st[1].rx_avail),
        .rx_ovr_o     (st[1].rx_overrun),
        .rx_data_o    (rxd[1]),
        .link_clk_i   (link_clk_b_i),
        .serial_in_i  (serial_in_chan_b_i),
        .serial_out_o (serial_out_chan_b_o)
    );

    // general status and interrupt request
    assign gstat = {st[1], st[0]};
    assign irq_any = |(gstat & ien_r);

    always_comb begin
        case (sel_s)
            scp_pkg::REG_CFG_A:  rd_mux = cfg_r[0];
            scp_pkg::REG_CFG_B:  rd_mux = cfg_r[1];
            scp_pkg::REG_RXQ_A:  rd_mux = rxd[0];
            scp_pkg::REG_RXQ_B:  rd_mux = rxd[1];
            scp_pkg::REG_STAT_A: rd_mux = {4'h0, st[0]};
            scp_pkg::REG_STAT_B: rd_mux = {4'h0, st[1]};
            scp_pkg::REG_IEN:    rd_mux = ien_r;
            scp_pkg::REG_GSTAT:  rd_mux = gstat;
            scp_pkg::REG_IVEC:   rd_mux = ivec_r;
            scp_pkg::REG_ICTL:   rd_mux = ictl_r;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        case (scp_pkg::scp_ackm_t'(ictl_r[1:0]))
            scp_pkg::SCP_ACK_VEC: begin
                ack_val = ivec_r;
                if (ictl_r[scp_pkg::VEC_MOD_BIT]) begin
                    ack_val[1:0] = irq_any && |(gstat[3:0] & ien_r[3:0]) ? 2'b00 : 2'b01;
                end
            end
            scp_pkg::SCP_ACK_CALL: ack_val = scp_pkg::CALL_OPCODE;
            default:               ack_val = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_data_bus_o    <= 8'h00;
            host_data_bus_oe_o <= 1'b0;
        end else if (!ack_n_s && irq_any
                     && ictl_r[1:0] != scp_pkg::SCP_ACK_FLOAT) begin
            host_data_bus_o    <= ack_val;
            host_data_bus_oe_o <= 1'b1;
        end else if (rd_cyc && !rd_block) begin
            host_data_bus_o    <= rd_mux;
            host_data_bus_oe_o <= 1'b1;
        end else begin
            host_data_bus_oe_o <= 1'b0;
        end
    end

    assign wm       = cfg_r[ch_sel][scp_pkg::CFG_WM_LO +: 2];
    assign rd_block = ch_rxq && !st[ch_sel].rx_avail
                      && (wm == scp_pkg::SCP_WAIT_RX || wm == scp_pkg::SCP_WAIT_ANY);
    assign wr_block = ch_txq && !st[ch_sel].tx_room
                      && (wm == scp_pkg::SCP_WAIT_TX || wm == scp_pkg::SCP_WAIT_ANY);

    // wait asserts at strobe edge, releases when possible
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_r <= 1'b0;
        end else if ((rd_fall && rd_block) || (wr_cyc && wr_n_d_r && wr_block)) begin
            wait_r <= 1'b1;
        end else if (!(rd_cyc && rd_block) && !(wr_cyc && wr_block)) begin
            wait_r <= 1'b0;
        end
    end
    assign wait_ready_n_o           = 1'b0;
    assign wait_ready_n_oe_o        = wait_r;
    assign interrupt_request_n_o    = 1'b0;
    assign interrupt_request_n_oe_o = irq_any;

    // system clock half rate and 16x generator
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sysclk_r  <= 1'b0;
            brg_cnt_r <= 4'h0;
            brg16_r   <= 1'b0;
        end else begin
            sysclk_r <= ~sysclk_r;
            if (brg_cnt_r == 4'(scp_pkg::BRG_DIV / 2 - 1)) begin
                brg_cnt_r <= 4'h0;
                brg16_r   <= ~brg16_r;
            end else begin
                brg_cnt_r <= brg_cnt_r + 4'h1;
            end
        end
    end

    // clock pin outputs, link clock as 1x
    assign txclk[0] = link_clk_a_i;
    assign txclk[1] = link_clk_b_i;
    assign rxclk[0] = link_clk_a_i;
    assign rxclk[1] = link_clk_b_i;
    assign first_clock_pin_a_oe_o  = cfg_r[0][scp_pkg::CFG_C1_LO];
    assign first_clock_pin_a_o     = txclk[0];
    assign first_clock_pin_b_oe_o  = cfg_r[1][scp_pkg::CFG_C1_LO];
    assign first_clock_pin_b_o     = txclk[1];
    assign second_clock_pin_a_oe_o = cfg_r[0][scp_pkg::CFG_C2_LO];
    assign second_clock_pin_a_o    = cfg_r[0][7] ? sysclk_r : brg16_r;
    assign second_clock_pin_b_oe_o = cfg_r[1][scp_pkg::CFG_C2_LO];
    assign second_clock_pin_b_o    = cfg_r[1][7] ? sysclk_r : rxclk[1];
endmodule // scp_top

// [verification/scp_line_model.sv]
module scp_line_model (
    // line pins
    output logic      link_clk_o,
    output logic      serial_in_o,
    input  wire logic serial_out_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_byte;
    int         rx_cnt = 0;

    // line clock of the equipment, free running
    initial begin
        link_clk_o = 1'b0;
        serial_in_o = 1'b1;
        forever #3 link_clk_o = ~link_clk_o;
    end
    // lsb first, changed on falling edge
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge link_clk_o);
            serial_in_o = f[i];
        end
    endtask
    initial begin
        forever begin
            @(posedge link_clk_o);
            if (serial_out_i === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    @(posedge link_clk_o);
                    rx_byte[i] = serial_out_i;
                end
                @(posedge link_clk_o);
                if (serial_out_i === 1'b1) rx_cnt++;
            end
        end
    end
endmodule // scp_line_model

// [verification/scp_top_asserts.sv]
module scp_top_asserts (
    // watched host and line ports
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic chip_select_n_i,
    input wire logic interrupt_ack_n_i,
    input wire logic host_data_bus_oe_o,
    input wire logic wait_ready_n_o,
    input wire logic wait_ready_n_oe_o,
    input wire logic interrupt_request_n_o,
    input wire logic interrupt_request_n_oe_o,
    input wire logic serial_out_chan_a_o,
    input wire logic serial_out_chan_b_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // pin behaviour against strobes, three core edges of latency
    chk_reset_quiet: assert property (disable iff (1'b0) rst_i ##1 rst_i |->
        serial_out_chan_a_o && serial_out_chan_b_o && !host_data_bus_oe_o
        && !wait_ready_n_oe_o && !interrupt_request_n_oe_o) else $error("pins busy in reset");
    chk_bus_float: assert property ((chip_select_n_i && interrupt_ack_n_i)[*4]
        |-> !host_data_bus_oe_o) else $error("bus driven without select");
    chk_rd_release: assert property ((read_strobe_n_i && interrupt_ack_n_i)[*4]
        |-> !host_data_bus_oe_o) else $error("bus driven without read");
    chk_read_drive: assert property (
        (!chip_select_n_i && !read_strobe_n_i && !wait_ready_n_oe_o)[*5]
        |-> host_data_bus_oe_o) else $error("read not driven");
    chk_wait_idle: assert property ((read_strobe_n_i && write_strobe_n_i)[*4]
        |-> !wait_ready_n_oe_o) else $error("wait outside a cycle");
    chk_wait_nocs: assert property (chip_select_n_i[*4]
        |-> !wait_ready_n_oe_o) else $error("wait without select");
    chk_wait_cause: assert property ($rose(wait_ready_n_oe_o) |->
        $past(read_strobe_n_i, 2) == 1'b0 || $past(write_strobe_n_i, 2) == 1'b0)
        else $error("wait without strobe");
    chk_ack_idle: assert property (
        (!interrupt_ack_n_i && chip_select_n_i && !interrupt_request_n_oe_o)[*4]
        |-> !host_data_bus_oe_o) else $error("ack answered with nothing pending");
    chk_drain_low: assert property (interrupt_request_n_oe_o || wait_ready_n_oe_o
        |-> !interrupt_request_n_o && !wait_ready_n_o) else $error("open drain pulls high");

    // main scenarios reached
    cov_read: cover property (!chip_select_n_i && host_data_bus_oe_o);
    cov_wait: cover property ($rose(wait_ready_n_oe_o));
    cov_ack: cover property (!interrupt_ack_n_i && host_data_bus_oe_o);
endmodule // scp_top_asserts

bind scp_top scp_top_asserts u_chk (.core_clk_i, .rst_i, .read_strobe_n_i, .write_strobe_n_i,
    .chip_select_n_i, .interrupt_ack_n_i, .host_data_bus_oe_o, .wait_ready_n_o,
    .wait_ready_n_oe_o, .interrupt_request_n_o, .interrupt_request_n_oe_o,
    .serial_out_chan_a_o, .serial_out_chan_b_o);

// [verification/scp_top_tb_top.sv]
module scp_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 20000;
    logic       clk, rst, rd_n, wr_n, cs_n, ack_n, w;
    logic [5:0] sel, b;
    logic [7:0] din, d, v, iv;
    wire        doe, wt, wt_oe, irq, irq_oe;
    wire  [7:0] dout;
    wire  [1:0] lclk, sin, so, p1, p1e, p2, p2e;
    int         error_cnt, n_checks, n0, k, cyc = 0;
    logic [5:0] ra[4] = '{scp_pkg::REG_CFG_A, scp_pkg::REG_IEN, scp_pkg::REG_IVEC,
                          scp_pkg::REG_ICTL};
    logic [7:0] rv[4] = '{scp_pkg::CFG_RST, scp_pkg::IEN_RST, scp_pkg::IVEC_RST,
                          scp_pkg::ICTL_RST};

    scp_top dut (
        .core_clk_i(clk), .rst_i(rst), .register_select_lines_i(sel),
        .host_data_bus_i(din), .host_data_bus_o(dout), .host_data_bus_oe_o(doe),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .chip_select_n_i(cs_n),
        .interrupt_ack_n_i(ack_n), .wait_ready_n_o(wt), .wait_ready_n_oe_o(wt_oe),
        .interrupt_request_n_o(irq), .interrupt_request_n_oe_o(irq_oe),
        .link_clk_a_i(lclk[0]), .serial_in_chan_a_i(sin[0]), .serial_out_chan_a_o(so[0]),
        .first_clock_pin_a_o(p1[0]), .first_clock_pin_a_oe_o(p1e[0]),
        .second_clock_pin_a_o(p2[0]), .second_clock_pin_a_oe_o(p2e[0]),
        .link_clk_b_i(lclk[1]), .serial_in_chan_b_i(sin[1]), .serial_out_chan_b_o(so[1]),
        .first_clock_pin_b_o(p1[1]), .first_clock_pin_b_oe_o(p1e[1]),
        .second_clock_pin_b_o(p2[1]), .second_clock_pin_b_oe_o(p2e[1])
    );
    // serial equipment on each channel
    scp_line_model la (.link_clk_o(lclk[0]), .serial_in_o(sin[0]), .serial_out_i(so[0]));
    scp_line_model lb (.link_clk_o(lclk[1]), .serial_in_o(sin[1]), .serial_out_i(so[1]));

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] x, input logic c);
        cs_n <= c;
        wr_n <= 1'b0;
        sel <= a;
        din <= x;
        tick(4);
        wr_n <= 1'b1;
        tick(4);
        cs_n <= 1'b1;
        tick(4);
    endtask
    task automatic rd(input logic [5:0] a, input logic c);
        cs_n <= c;
        rd_n <= 1'b0;
        sel <= a;
        tick(4);
        #1 w = wt_oe;
        for (k = 0; wt_oe !== 1'b0 && k < 2000; k++) tick(1);
        tick(4);
        #1 d = dout;
        check("bus drive", doe, !c);
        tick(1);
        rd_n <= 1'b1;
        tick(4);
        cs_n <= 1'b1;
        tick(4);
    endtask
    task automatic ack();
        ack_n <= 1'b0;
        tick(4);
        #1 d = dout;
        w = doe;
        tick(1);
        ack_n <= 1'b1;
        tick(4);
    endtask
    function automatic logic [7:0] ack_exp(input logic [1:0] m, input logic [7:0] vec);
        case (m)
            2'b01: return vec;
            2'b10: return scp_pkg::CALL_OPCODE;
            default: return 8'h00;
        endcase
    endfunction

    // core clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        rst = 1'b1;
        {rd_n, wr_n, cs_n, ack_n} = 4'hF;
        sel = 6'h00;
        din = 8'h00;
        void'($urandom(21));
        tick(2);
        #1 check("reset pins", {doe, wt_oe, irq_oe, so}, 8'h03);
        tick(1);
        rst <= 1'b0;
        tick(3);
        foreach (ra[i]) begin
            rd(ra[i], 1'b0);
            check("reset value", d, rv[i]);
        end
        // random vectors, then accesses without select
        repeat (3) begin
            iv = 8'($urandom);
            wr(scp_pkg::REG_IVEC, iv, 1'b0);
            rd(scp_pkg::REG_IVEC, 1'b0);
            check("vector reg", d, iv);
        end
        wr(scp_pkg::REG_IVEC, ~iv, 1'b1);
        rd(scp_pkg::REG_IVEC, 1'b1);
        rd(scp_pkg::REG_IVEC, 1'b0);
        check("vector kept", d, iv);
        // both directions on each channel, clock pins enabled
        for (int ch = 0; ch < 2; ch++) begin
            b = ch ? scp_pkg::REG_CFG_B : scp_pkg::REG_CFG_A;
            wr(b, 8'h63, 1'b0);
            check("clock pins", {p1e[ch], p2e[ch]}, 8'h03);
            v = 8'($urandom);
            wr(b + 6'h01, v, 1'b0);
            check("line byte", ch ? lb.rx_byte : la.rx_byte, v);
            v = 8'($urandom);
            if (ch == 0) la.send_byte(v);
            else lb.send_byte(v);
            tick(4);
            rd(b + 6'h02, 1'b0);
            check("rx byte", d, v);
        end
        // empty receive read, wait off then wait on receive
        rd(scp_pkg::REG_RXQ_A, 1'b0);
        check("no wait", w, 1'b0);
        wr(scp_pkg::REG_CFG_A, 8'h0B, 1'b0);
        v = 8'($urandom);
        fork
            rd(scp_pkg::REG_RXQ_A, 1'b0);
            begin
                tick(20);
                la.send_byte(v);
            end
        join
        check("wait seen", w, 1'b1);
        check("stalled byte", d, v);
        // interrupt on transmit room, every acknowledge answer
        wr(scp_pkg::REG_IEN, 8'h04, 1'b0);
        check("irq on", irq_oe, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(scp_pkg::REG_ICTL, 8'(m), 1'b0);
            ack();
            check("ack drive", w, m != 0);
            if (m != 0) check("ack data", d, ack_exp(2'(m), iv));
        end
        wr(scp_pkg::REG_IEN, 8'h00, 1'b0);
        ack();
        check("ack ignored", {irq_oe, w}, 8'h00);
        // loopback keeps the line marking
        wr(scp_pkg::REG_CFG_A, 8'h07, 1'b0);
        n0 = la.rx_cnt;
        wr(scp_pkg::REG_TXQ_A, 8'h00, 1'b0);
        tick(20);
        check("loop mark", 8'(la.rx_cnt - n0), 8'h00);
        print_verdict();
    end
endmodule // scp_top_tb_top
